// [hdl/tap_debug_port.sv]
/*
 * Four-wire test access port with debug hooks: instruction and data
 * registers, private debug data registers, fuse and lock gating, and the
 * CPU-to-debugger message register. Assumes test pins asynchronous to
 * clk_i and sampled here; fuses, lock bits and the register port are
 * synchronous to clk_i. Test clock must be well below half of clk_i.
 */
// The address map and the strobed register port were chosen for this implementation.
// Functional notes
// - Sixteen-state controller stepped by TMS on TCK rise
// - Power-on reset puts controller in reset state
// - Every shift register moves LSB first
// - Instruction capture value one shifted out
// - Instruction output changes only in Update-IR, or to the reset value in the reset state
// - Data shift outputs values captured at Capture-DR
// - Latched data outputs change only in Update-DR; access and break flow/step flags also clear without debug enable
// - Five high TMS edges force reset state
// - Opcodes 0x8 to 0xB are debug instructions
// - Debugger acts through injected CPU instructions
// - Break on flow change and single step
// - Four break resources in five layouts
// - Debug needs fuse, disabled by either lock bit
// - Port needs fuse and cleared disable bit
// - CPU message write sets dirty flag
// - Message read gives dirty flag in MSB
// - Message access only with fuse and debugger enable
// - No separate test reset pin
// - Unprogrammed port fuse holds reset, frees pins
`timescale 1ns/10ps
`include "tap_regs.svh"
module tap_debug_port #(
    parameter int SR_W = 16,
    parameter int CPU_W = 16
) (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic tck_i,
    input wire logic tms_i,
    input wire logic tdi_i,
    output logic tdo_o,
    output logic tdo_oe_o,
    input wire logic port_enable_fuse_i,
    input wire logic debug_enable_fuse_i,
    input wire logic lock_bit_one_i,
    input wire logic lock_bit_two_i,
    input wire logic [1:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    output logic pins_to_gpio_o,
    output logic debug_active_o,
    output logic [3:0] instr_o,
    output logic [2:0] bp_config_o,
    output logic break_flow_o,
    output logic break_step_o,
    output logic [CPU_W-1:0] cpu_instr_o,
    output logic cpu_instr_valid_o
);
    if (SR_W < 16 || CPU_W != 16) begin : g_bad_params
        $error("tap_debug_port: SR_W must be at least 16 and CPU_W 16");
    end

    tap_step_if step ();

    tap_fsm u_fsm (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .step(step)
    );

    // Pin synchronisers: tck, tms, tdi
    logic [2:0] sync1_r;
    logic [2:0] sync2_r;
    logic tck_d_r;
    logic [7:0] mcu_ctrl_r;
    logic [7:0] msg_r;
    logic [7:0] shared_io_r;
    logic dirty_r;
    logic access_en_r;
    logic [`IR_WIDTH-1:0] ir_sr_r;
    logic [SR_W-1:0] sr_r;
    logic [7:0] rdata_r;
    logic tdo_r;
    logic tdo_oe_r;
    logic gpio_r;
    logic dbg_r;
    logic [3:0] instr_r;
    logic [2:0] bp_cfg_r;
    logic brk_flow_r;
    logic brk_step_r;
    logic [CPU_W-1:0] cpu_instr_r;
    logic cpu_valid_r;

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            sync1_r <= 3'h0;
            sync2_r <= 3'h0;
            tck_d_r <= 1'b0;
        end else begin
            sync1_r <= {tck_i, tms_i, tdi_i};
            sync2_r <= sync1_r;
            tck_d_r <= sync2_r[2];
        end
    end

    // Edge events and gating; no test reset pin exists
    wire tck_s = sync2_r[2];
    wire tms_s = sync2_r[1];
    wire tdi_s = sync2_r[0];
    wire port_en = port_enable_fuse_i && !mcu_ctrl_r[`PORT_DISABLE_POS];
    wire rise = port_en && tck_s && !tck_d_r;
    wire fall = port_en && !tck_s && tck_d_r;
    wire debug_en = port_en && debug_enable_fuse_i && !lock_bit_one_i && !lock_bit_two_i;

    assign step.rise = rise;
    assign step.tms = tms_s;
    assign step.hold_rst = !port_en;

    tap_pkg::tap_state_t st;
    assign st = step.state;

    // Private instruction decode, bypass otherwise
    wire sel_a = debug_en && instr_r == `OP_DEBUG_A;
    wire sel_b = debug_en && instr_r == `OP_DEBUG_B;
    wire sel_c = debug_en && instr_r == `OP_DEBUG_C;
    wire sel_d = debug_en && instr_r == `OP_DEBUG_D;
    wire [4:0] dr_len = sel_a ? `LEN_ACCESS : sel_b ? `LEN_MSG : sel_c ? `LEN_CPU :
                        sel_d ? `LEN_BREAK : `LEN_BYPASS;

    // Captured parallel values per data register
    wire [SR_W-1:0] cap_msg = SR_W'({dirty_r, msg_r[6:0]});
    wire [SR_W-1:0] cap_brk = SR_W'({brk_step_r, brk_flow_r, bp_cfg_r});
    wire [SR_W-1:0] dr_capture = sel_a ? SR_W'(access_en_r) : sel_b ? cap_msg :
                                 sel_c ? SR_W'(cpu_instr_r) : sel_d ? cap_brk : '0;

    // LSB leaves first, TDI enters at the register's top bit
    wire [SR_W-1:0] top_bit = SR_W'(1) << (dr_len - 5'h1);
    wire [SR_W-1:0] sr_shift = (sr_r >> 1) | (tdi_s ? top_bit : '0);
    wire [`IR_WIDTH-1:0] ir_shift = {tdi_s, ir_sr_r[`IR_WIDTH-1:1]};

    wire cap_ir_ev = rise && st == tap_pkg::CAP_IR;
    wire cap_dr_ev = rise && st == tap_pkg::CAP_DR;
    wire upd_ir_ev = fall && st == tap_pkg::UPD_IR;
    wire upd_dr_ev = fall && st == tap_pkg::UPD_DR;
    wire shifting = st == tap_pkg::SHIFT_IR || st == tap_pkg::SHIFT_DR;

    wire [2:0] brk_cfg_new = sr_r[`BRK_CFG_LSB +: 3];
    wire brk_cfg_ok = brk_cfg_new <= 3'(tap_pkg::BP_2PROG_RANGE_DATA);

    // Register port decode; message location shared with plain storage
    wire msg_route = debug_enable_fuse_i && access_en_r;
    wire wr_ctrl = wr_i && addr_i == `MCU_CTRL_OFS;
    wire wr_msg = wr_i && addr_i == `DBG_MSG_OFS && msg_route;
    wire wr_plain = wr_i && addr_i == `DBG_MSG_OFS && !msg_route;
    wire [7:0] msg_view = {dirty_r, msg_r[6:0]};
    wire [7:0] status_view = {dbg_r, !gpio_r, dirty_r, access_en_r, instr_r};
    wire [7:0] rd_mux = addr_i == `MCU_CTRL_OFS ? mcu_ctrl_r :
                        addr_i == `DBG_MSG_OFS ? (msg_route ? msg_view : shared_io_r) :
                        addr_i == `TAP_STATUS_OFS ? status_view : 8'h00;

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            mcu_ctrl_r <= `MCU_CTRL_RESET;
            msg_r <= `MSG_RESET;
            shared_io_r <= 8'h00;
            rdata_r <= 8'h00;
        end else begin
            mcu_ctrl_r <= wr_ctrl ? wdata_i : mcu_ctrl_r;
            msg_r <= wr_msg ? wdata_i : msg_r;
            shared_io_r <= wr_plain ? wdata_i : shared_io_r;
            rdata_r <= rd_i ? rd_mux : 8'h00;
        end
    end

    // Dirty flag: CPU write wins over debugger clear
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            dirty_r <= 1'b0;
        end else if (wr_msg) begin
            dirty_r <= 1'b1;
        end else if (upd_dr_ev && sel_b) begin
            dirty_r <= 1'b0;
        end
    end

    // Instruction path
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ir_sr_r <= `IR_CAPTURE;
            instr_r <= `IR_RESET;
        end else if (st == tap_pkg::TLR) begin
            instr_r <= `IR_RESET;
        end else if (cap_ir_ev) begin
            ir_sr_r <= `IR_CAPTURE;
        end else if (rise && st == tap_pkg::SHIFT_IR) begin
            ir_sr_r <= ir_shift;
        end else if (upd_ir_ev) begin
            instr_r <= ir_sr_r;
        end
    end

    // Data path
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            sr_r <= '0;
        end else if (cap_dr_ev) begin
            sr_r <= dr_capture;
        end else if (rise && st == tap_pkg::SHIFT_DR) begin
            sr_r <= sr_shift;
        end
    end

    // Latched data outputs, loaded in Update-DR; access and break flow/step flags cleared without debug enable
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            access_en_r <= 1'b0;
            bp_cfg_r <= `BRK_CFG_RESET;
            brk_flow_r <= 1'b0;
            brk_step_r <= 1'b0;
            cpu_instr_r <= '0;
            cpu_valid_r <= 1'b0;
        end else begin
            cpu_valid_r <= upd_dr_ev && sel_c;
            if (!debug_en) begin
                access_en_r <= 1'b0;
                brk_flow_r <= 1'b0;
                brk_step_r <= 1'b0;
            end else if (upd_dr_ev && sel_a) begin
                access_en_r <= sr_r[0];
            end else if (upd_dr_ev && sel_d) begin
                bp_cfg_r <= brk_cfg_ok ? brk_cfg_new : bp_cfg_r;
                brk_flow_r <= sr_r[`BRK_FLOW_POS];
                brk_step_r <= sr_r[`BRK_STEP_POS];
            end
            if (upd_dr_ev && sel_c) begin
                cpu_instr_r <= sr_r[CPU_W-1:0];
            end
        end
    end

    // Serial output on the falling test clock
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            tdo_r <= 1'b0;
            tdo_oe_r <= 1'b0;
            gpio_r <= 1'b1;
            dbg_r <= 1'b0;
        end else begin
            gpio_r <= !port_en;
            dbg_r <= debug_en;
            if (!port_en) begin
                tdo_oe_r <= 1'b0;
            end else if (fall) begin
                tdo_r <= st == tap_pkg::SHIFT_IR ? ir_sr_r[0] : sr_r[0];
                tdo_oe_r <= shifting;
            end
        end
    end

    assign tdo_o = tdo_r;
    assign tdo_oe_o = tdo_oe_r;
    assign rdata_o = rdata_r;
    assign pins_to_gpio_o = gpio_r;
    assign debug_active_o = dbg_r;
    assign instr_o = instr_r;
    assign bp_config_o = bp_cfg_r;
    assign break_flow_o = brk_flow_r;
    assign break_step_o = brk_step_r;
    assign cpu_instr_o = cpu_instr_r;
    assign cpu_instr_valid_o = cpu_valid_r;

    tdo_float_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (fall && !shifting) |=> !tdo_oe_o)
        else $error("TDO driven outside a shift state");

    ir_capture_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        cap_ir_ev |=> ir_sr_r == `IR_CAPTURE)
        else $error("instruction capture value not one");

    ir_update_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        $changed(instr_o) |-> $past(upd_ir_ev) || $past(st == tap_pkg::TLR))
        else $error("instruction changed outside Update-IR");

    dr_update_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        $changed(cpu_instr_o) |-> $past(upd_dr_ev && sel_c))
        else $error("CPU instruction changed outside Update-DR");

    dirty_set_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        wr_msg |=> dirty_r)
        else $error("message write did not set dirty flag");

    msg_read_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (rd_i && addr_i == `DBG_MSG_OFS && msg_route) |=> rdata_o == $past(msg_view))
        else $error("message read lacks dirty flag in MSB");

    lock_gate_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (lock_bit_one_i || lock_bit_two_i) |=> !debug_active_o)
        else $error("debug active with a lock bit set");

    port_gate_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        !port_en |=> pins_to_gpio_o && !tdo_oe_o ##0 st == tap_pkg::TLR)
        else $error("disabled port not held in reset");

    cpu_pulse_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (upd_dr_ev && sel_c) |=> cpu_instr_valid_o ##1 !cpu_instr_valid_o)
        else $error("debug instruction C update gave no single pulse");

    shift_ir_c: cover property (@(posedge clk_i) disable iff (!resetn_i)
        rise && st == tap_pkg::SHIFT_IR && tms_s);
    cpu_inject_c: cover property (@(posedge clk_i) disable iff (!resetn_i)
        cpu_valid_r);
    dirty_clear_c: cover property (@(posedge clk_i) disable iff (!resetn_i)
        dirty_r ##1 !dirty_r);

endmodule : tap_debug_port

// [hdl/tap_regs.svh]
/*
 * Offsets, field positions, reset values and opcodes of the test access
 * port and its debug hooks. Assumes inclusion by bare name.
 */
`ifndef TAP_REGS_SVH
`define TAP_REGS_SVH

// Register port offsets
`define MCU_CTRL_OFS 2'h0
`define DBG_MSG_OFS 2'h1
`define TAP_STATUS_OFS 2'h2

// Field positions and reset values
`define PORT_DISABLE_POS 7
`define MSG_DIRTY_POS 7
`define MCU_CTRL_RESET 8'h00
`define MSG_RESET 8'h00

// Instruction register
`define IR_WIDTH 4
`define IR_CAPTURE 4'h1
`define IR_RESET 4'h1
`define OP_DEBUG_A 4'h8
`define OP_DEBUG_B 4'h9
`define OP_DEBUG_C 4'ha
`define OP_DEBUG_D 4'hb

// Data register lengths
`define LEN_BYPASS 5'h01
`define LEN_ACCESS 5'h01
`define LEN_MSG 5'h08
`define LEN_CPU 5'h10
`define LEN_BREAK 5'h06

// Break control data register fields
`define BRK_CFG_LSB 0
`define BRK_FLOW_POS 3
`define BRK_STEP_POS 4
`define BRK_CFG_RESET 3'h0

// Consecutive high TMS edges that force reset
`define TLR_ONES 3'h5

`endif

// [hdl/tap_pkg.sv]
/*
 * Types shared by the test access port modules.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package tap_pkg;

    typedef enum logic [3:0] {
        TLR, RTI, SEL_DR, CAP_DR, SHIFT_DR, EXIT1_DR, PAUSE_DR, EXIT2_DR, UPD_DR,
        SEL_IR, CAP_IR, SHIFT_IR, EXIT1_IR, PAUSE_IR, EXIT2_IR, UPD_IR
    } tap_state_t;

    // Break point resource layouts
    typedef enum logic [2:0] {
        BP_4PROG, BP_3PROG_1DATA, BP_2PROG_2DATA, BP_2PROG_RANGE_PROG, BP_2PROG_RANGE_DATA
    } bp_cfg_t;

endpackage : tap_pkg

// [hdl/tap_step_if.sv]
/*
 * Carries test clock edge events and the controller state between the
 * port logic and its state machine. Assumes one shared system clock.
 */
`timescale 1ns/10ps
interface tap_step_if;
    logic rise;
    logic tms;
    logic hold_rst;
    tap_pkg::tap_state_t state;

    modport ctrl (input rise, input tms, input hold_rst, output state);
    modport user (output rise, output tms, output hold_rst, input state);
endinterface : tap_step_if

// [hdl/tap_fsm.sv]
/*
 * Sixteen-state test access port controller, stepped on each detected
 * rising test clock edge. Assumes edge events and TMS already synchronised.
 */
`timescale 1ns/10ps
`include "tap_regs.svh"
module tap_fsm (
    input wire logic clk_i,
    input wire logic resetn_i,
    tap_step_if.ctrl step
);
    tap_pkg::tap_state_t state_r;
    tap_pkg::tap_state_t state_nxt;
    logic [2:0] ones_r;

    assign step.state = state_r;

    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            tap_pkg::TLR: state_nxt = step.tms ? tap_pkg::TLR : tap_pkg::RTI;
            tap_pkg::RTI: state_nxt = step.tms ? tap_pkg::SEL_DR : tap_pkg::RTI;
            tap_pkg::SEL_DR: state_nxt = step.tms ? tap_pkg::SEL_IR : tap_pkg::CAP_DR;
            tap_pkg::CAP_DR: state_nxt = step.tms ? tap_pkg::EXIT1_DR : tap_pkg::SHIFT_DR;
            tap_pkg::SHIFT_DR: state_nxt = step.tms ? tap_pkg::EXIT1_DR : tap_pkg::SHIFT_DR;
            tap_pkg::EXIT1_DR: state_nxt = step.tms ? tap_pkg::UPD_DR : tap_pkg::PAUSE_DR;
            tap_pkg::PAUSE_DR: state_nxt = step.tms ? tap_pkg::EXIT2_DR : tap_pkg::PAUSE_DR;
            tap_pkg::EXIT2_DR: state_nxt = step.tms ? tap_pkg::UPD_DR : tap_pkg::SHIFT_DR;
            tap_pkg::UPD_DR: state_nxt = step.tms ? tap_pkg::SEL_DR : tap_pkg::RTI;
            tap_pkg::SEL_IR: state_nxt = step.tms ? tap_pkg::TLR : tap_pkg::CAP_IR;
            tap_pkg::CAP_IR: state_nxt = step.tms ? tap_pkg::EXIT1_IR : tap_pkg::SHIFT_IR;
            tap_pkg::SHIFT_IR: state_nxt = step.tms ? tap_pkg::EXIT1_IR : tap_pkg::SHIFT_IR;
            tap_pkg::EXIT1_IR: state_nxt = step.tms ? tap_pkg::UPD_IR : tap_pkg::PAUSE_IR;
            tap_pkg::PAUSE_IR: state_nxt = step.tms ? tap_pkg::EXIT2_IR : tap_pkg::PAUSE_IR;
            tap_pkg::EXIT2_IR: state_nxt = step.tms ? tap_pkg::UPD_IR : tap_pkg::SHIFT_IR;
            tap_pkg::UPD_IR: state_nxt = step.tms ? tap_pkg::SEL_DR : tap_pkg::RTI;
        endcase
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state_r <= tap_pkg::TLR;
        end else if (step.hold_rst) begin
            state_r <= tap_pkg::TLR;
        end else if (step.rise) begin
            state_r <= state_nxt;
        end
    end

    // Run of high TMS edges, saturating
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ones_r <= 3'h0;
        end else if (step.rise) begin
            ones_r <= !step.tms ? 3'h0 : (ones_r == `TLR_ONES ? ones_r : ones_r + 3'h1);
        end
    end

    tlr_five_ones_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        ones_r == `TLR_ONES |-> state_r == tap_pkg::TLR)
        else $error("five high TMS edges did not reach reset state");

    rti_exit_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (step.rise && !step.hold_rst && state_r == tap_pkg::TLR && !step.tms)
        |=> state_r == tap_pkg::RTI)
        else $error("low TMS in reset state did not reach idle");

endmodule : tap_fsm

// [test/jtag_probe.sv]
/*
 * Model of the external test controller on the four-wire port.
 * Assumes clk_i is the bench clock; TCK runs only within frames.
 */
`timescale 1ns/10ps
module jtag_probe (
    input wire logic clk_i,
    input wire logic tdo_i,
    input wire logic tdo_oe_i,
    output logic tck_o,
    output logic tms_o,
    output logic tdi_o
);
    initial begin
        tck_o = 1'b0;
        tms_o = 1'b1;
        tdi_o = 1'b0;
    end

    // One TCK period, 500 ns low then 300 ns high
    task automatic tick(input logic m, input logic d, output logic q);
        @(posedge clk_i);
        tck_o <= 1'b0;
        tms_o <= m;
        tdi_o <= d;
        repeat (5) @(posedge clk_i);
        q = tdo_oe_i ? tdo_i : 1'b1;  // Pulled high when undriven
        tck_o <= 1'b1;
        repeat (2) @(posedge clk_i);
    endtask : tick

    // Closing fall; clock then stands still, TDI changes
    task automatic idle();
        @(posedge clk_i);
        tck_o <= 1'b0;
        tdi_o <= ~tdi_o;
        repeat (5) @(posedge clk_i);
    endtask : idle

    task automatic scan(input logic ir, input logic [15:0] din, input int n,
                        output logic [15:0] dout);
        logic q;
        dout = 16'h0000;
        tick(1'b1, 1'b0, q);
        if (ir) tick(1'b1, 1'b0, q);
        tick(1'b0, 1'b0, q);
        tick(1'b0, 1'b0, q);
        for (int i = 0; i < n; i++) begin
            tick(i == n - 1, din[i], q);
            dout[i] = q;
        end
        tick(1'b1, 1'b0, q);
        tick(1'b0, 1'b0, q);
        idle();
    endtask : scan
endmodule : jtag_probe

// [test/jtag_tap_debug_port_bench.sv]
/*
 * Self-checking bench for the test access port and its debug hooks.
 * Assumes the design files and the probe model are compiled first.
 */
`timescale 1ns/10ps
`include "tap_regs.svh"
module jtag_tap_debug_port_bench;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic tck, tms, tdi, tdo, tdo_oe, q;
    logic port_fuse = 1'b1;
    logic debug_fuse = 1'b1;
    logic lock_one = 1'b0;
    logic lock_two = 1'b0;
    logic [1:0] addr = 2'h0;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [7:0] rdata;
    logic gpio, active, flow, step, cpu_valid;
    logic [3:0] instr;
    logic [2:0] bp_cfg;
    logic [15:0] cpu_instr, d;
    logic [15:0] n_valid = 16'h0000;
    int n_fail = 0;
    int compares = 0;
    int cycles = 0;
    // Break control shift value beside the expected step, flow and layout
    logic [10:0] brk_rows [7] = '{{6'h00, 5'h00}, {6'h09, 5'h09}, {6'h12, 5'h12},
        {6'h1b, 5'h1b}, {6'h04, 5'h04}, {6'h2f, 5'h0c}, {6'h15, 5'h14}};
    // Debug fuse, lock one, lock two beside the expected enable
    logic [3:0] lock_rows [4] = '{4'ha, 4'h0, 4'h9, 4'hc};
    localparam logic [9:0] TMS_SEQ = 10'b1000111110;

    always #50 clk = ~clk;

    tap_debug_port u_tap_debug_port (.clk_i(clk), .resetn_i(resetn), .tck_i(tck),
        .tms_i(tms), .tdi_i(tdi), .tdo_o(tdo), .tdo_oe_o(tdo_oe),
        .port_enable_fuse_i(port_fuse), .debug_enable_fuse_i(debug_fuse),
        .lock_bit_one_i(lock_one), .lock_bit_two_i(lock_two), .addr_i(addr),
        .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .pins_to_gpio_o(gpio),
        .debug_active_o(active), .instr_o(instr), .bp_config_o(bp_cfg),
        .break_flow_o(flow), .break_step_o(step), .cpu_instr_o(cpu_instr),
        .cpu_instr_valid_o(cpu_valid));

    jtag_probe u_jtag_probe (.clk_i(clk), .tdo_i(tdo), .tdo_oe_i(tdo_oe), .tck_o(tck),
        .tms_o(tms), .tdi_o(tdi));

    always @(posedge clk) begin
        if (cpu_valid === 1'b1) n_valid <= n_valid + 16'h0001;
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_fail = n_fail + 1;
            tally_and_finish();
        end
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic wr_reg(input logic [1:0] a, input logic [7:0] v);
        @(posedge clk);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg

    // Read data stands one cycle only, then returns to zero
    task automatic rd_reg(input logic [1:0] a, input logic [7:0] exp);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 check({8'h00, rdata}, {8'h00, exp});
        @(posedge clk);
        #1 check({8'h00, rdata}, 16'h0000);
    endtask : rd_reg

    task automatic tally_and_finish();
        if (n_fail == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : tally_and_finish

    initial begin
        repeat (2) @(posedge clk);
        #1 check({gpio, tdo_oe, instr}, {2'b10, `IR_RESET});
        @(posedge clk);
        resetn <= 1'b1;
        repeat (3) @(posedge clk);
        rd_reg(`TAP_STATUS_OFS, 8'hc1);
        rd_reg(`MCU_CTRL_OFS, `MCU_CTRL_RESET);
        // One low TMS edge leaves the reset state for idle
        u_jtag_probe.tick(1'b0, 1'b0, q);
        u_jtag_probe.idle();
        u_jtag_probe.scan(1'b1, {12'h000, `OP_DEBUG_C}, 4, d);
        check(d, {12'h000, `IR_CAPTURE});
        check({12'h000, instr}, {12'h000, `OP_DEBUG_C});
        u_jtag_probe.scan(1'b0, 16'h1234, 16, d);
        u_jtag_probe.scan(1'b0, 16'habcd, 16, d);
        check(d, 16'h1234);
        check(cpu_instr, 16'habcd);
        check(n_valid, 16'h0002);
        u_jtag_probe.scan(1'b1, {12'h000, `IR_RESET}, 4, d);
        u_jtag_probe.scan(1'b0, 16'h0003, 2, d);
        check(d, 16'h0002);
        u_jtag_probe.scan(1'b1, {12'h000, `OP_DEBUG_D}, 4, d);
        for (int i = 0; i < 7; i++) begin
            u_jtag_probe.scan(1'b0, {10'h000, brk_rows[i][10:5]}, 6, d);
            check({11'h000, step, flow, bp_cfg}, {11'h000, brk_rows[i][4:0]});
        end
        wr_reg(`DBG_MSG_OFS, 8'h5a);
        rd_reg(`DBG_MSG_OFS, 8'h5a);
        u_jtag_probe.scan(1'b1, {12'h000, `OP_DEBUG_A}, 4, d);
        u_jtag_probe.scan(1'b0, 16'h0001, 1, d);
        wr_reg(`DBG_MSG_OFS, 8'h33);
        rd_reg(`DBG_MSG_OFS, 8'hb3);
        rd_reg(`TAP_STATUS_OFS, 8'hf8);
        u_jtag_probe.scan(1'b1, {12'h000, `OP_DEBUG_B}, 4, d);
        u_jtag_probe.scan(1'b0, 16'h0000, 8, d);
        check(d, 16'h00b3);
        rd_reg(`DBG_MSG_OFS, 8'h33);
        // Abandon a data shift midway with five high TMS edges
        u_jtag_probe.scan(1'b1, {12'h000, `OP_DEBUG_C}, 4, d);
        for (int i = 9; i >= 0; i--) u_jtag_probe.tick(TMS_SEQ[i], 1'b1, q);
        u_jtag_probe.idle();
        check({11'h000, tdo_oe, instr}, {12'h000, `IR_RESET});
        // The walk passes Update-DR: word shifted twice with ones latches
        check(cpu_instr, 16'heaf3);
        check(n_valid, 16'h0003);
        wr_reg(2'h3, 8'hff);
        rd_reg(2'h3, 8'h00);
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            {debug_fuse, lock_one, lock_two} <= lock_rows[i][3:1];
            repeat (2) @(posedge clk);
            #1 check({15'h0000, active}, {15'h0000, lock_rows[i][0]});
        end
        check({14'h0000, step, flow}, 16'h0000);
        u_jtag_probe.scan(1'b1, {12'h000, `OP_DEBUG_C}, 4, d);
        u_jtag_probe.scan(1'b0, 16'h0003, 2, d);
        check(d, 16'h0002);
        check(cpu_instr, 16'heaf3);
        lock_one <= 1'b0;
        wr_reg(`MCU_CTRL_OFS, 8'h80);
        rd_reg(`MCU_CTRL_OFS, 8'h80);
        check({11'h000, gpio, instr}, {11'h001, `IR_RESET});
        u_jtag_probe.scan(1'b1, {12'h000, `OP_DEBUG_A}, 4, d);
        check(d, 16'h000f);
        check({12'h000, instr}, {12'h000, `IR_RESET});
        wr_reg(`MCU_CTRL_OFS, 8'h00);
        port_fuse <= 1'b0;
        repeat (2) @(posedge clk);
        #1 check({15'h0000, gpio}, 16'h0001);
        @(posedge clk);
        port_fuse <= 1'b1;
        repeat (2) @(posedge clk);
        #1 check({15'h0000, gpio}, 16'h0000);
        @(posedge clk);
        resetn <= 1'b0;
        repeat (2) @(posedge clk);
        #1 check({11'h000, gpio, instr}, {11'h001, `IR_RESET});
        check(cpu_instr, 16'h0000);
        tally_and_finish();
    end
endmodule : jtag_tap_debug_port_bench
